// ===== rtl/chsto_defines.svh
// register offsets, field positions and reset values of the card status block
`ifndef CHSTO_DEFINES_SVH
`define CHSTO_DEFINES_SVH
`define CHSTO_ADDR_W 8
`define CHSTO_OFF_CLOCK_CTRL 8'h04
`define CHSTO_OFF_MAIN_STATUS 8'h08
`define CHSTO_OFF_SECONDARY_STATUS 8'h0c
`define CHSTO_OFF_INTERRUPT_ENABLE 8'h10
`define CHSTO_OFF_RESPONSE_WAIT_LIMIT 8'h14
`define CHSTO_OFF_READ_DATA_WAIT_LIMIT 8'h18
`define CHSTO_STATUS_W 14
`define CHSTO_BIT_CMD_COMPLETE 13
`define CHSTO_BIT_TRANSFER_DONE 12
`define CHSTO_BIT_LINE3_EDGE 11
`define CHSTO_BIT_RX_READY 10
`define CHSTO_BIT_TX_READY 9
`define CHSTO_BIT_RESERVED 8
`define CHSTO_BIT_RESP_CRC 7
`define CHSTO_BIT_READ_CRC 6
`define CHSTO_BIT_WRITE_CRC 5
`define CHSTO_BIT_RESP_TIMEOUT 4
`define CHSTO_BIT_READ_TIMEOUT 3
`define CHSTO_BIT_RESP_DONE 2
`define CHSTO_BIT_BUSY_DONE 1
`define CHSTO_BIT_DATA_DONE 0
`define CHSTO_MAIN_STATUS_RESET 14'h0200
`define CHSTO_READ_CLEAR_MASK 14'h39ff
`define CHSTO_WRITABLE_MASK 14'h3eff
`define CHSTO_SEC_FIFO_FULL 6
`define CHSTO_SEC_FIFO_EMPTY 5
`define CHSTO_SEC_LINE3_LEVEL 4
`define CHSTO_SEC_RX_SHIFT_FULL 3
`define CHSTO_SEC_TX_SHIFT_EMPTY 2
`define CHSTO_SEC_CLOCK_STOPPED 1
`define CHSTO_SEC_CARD_BUSY 0
`define CHSTO_CLK_DIVIDER_LSB 0
`define CHSTO_CLK_ENABLE_BIT 8
`define CHSTO_CLK_EDGE_LSB 9
`define CHSTO_CLK_CTRL_RESET 11'h000
`define CHSTO_RESP_COUNT_LSB 0
`define CHSTO_READ_HIGH_LSB 8
`define CHSTO_READ_LOW_LSB 0
`define CHSTO_WAIT_LIMIT_RESET 32'h00000000
`endif

// ===== rtl/chsto_pkg.sv
// types shared by the card status and time-out block
package chsto_pkg;
    typedef enum logic {CHSTO_IDLE, CHSTO_WAITING} chsto_wait_t;
    typedef enum logic [1:0] {
        CHSTO_EDGE_OFF, CHSTO_EDGE_RISE, CHSTO_EDGE_FALL, CHSTO_EDGE_BOTH
    } chsto_edge_t;
endpackage

// ===== rtl/chsto_regs.sv
// status, interrupt enable and time-out registers of the card host
`include "chsto_defines.svh"

// Operation
// - data done flag set when transfer fully sent
// - secondary status never raises an interrupt
// - line 3 pin level in secondary bit 4
// - receive shift full in secondary bit 3
// - transmit shift empty in secondary bit 2
// - card clock held low, reported in bit 1
// - card busy shown in secondary bit 0
// - enabled status bit rising raises interrupt
// - enables sit at status bit positions
// - response wait limit counts memory clock cycles
// - response time-out flag interrupts when enabled
// - read limit is 26 bits, zero disables
// - low 16 read limit bits, read time-out
// - read time-out flag interrupts when enabled
// - reading main status clears all but ready flags
// - memory clock is function clock over 2(div+1)
// - clock enable cleared holds card clock low
module chsto_regs #(
    parameter int RESP_W = 8,
    parameter int READ_W = 26,
    parameter int DIV_W = 8
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`CHSTO_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic CMD_COMPLETE,
    input wire logic TRANSFER_DONE,
    input wire logic DATA_DONE,
    input wire logic RESP_DONE,
    input wire logic BUSY_DONE,
    input wire logic RESP_CRC_ERROR,
    input wire logic READ_CRC_ERROR,
    input wire logic WRITE_CRC_ERROR,
    input wire logic RX_READY_SET,
    input wire logic RX_READY_CLEAR,
    input wire logic TX_READY_SET,
    input wire logic TX_READY_CLEAR,
    input wire logic RESP_WAIT_START,
    input wire logic RESP_ARRIVED,
    input wire logic READ_WAIT_START,
    input wire logic READ_ARRIVED,
    input wire logic RX_SHIFT_FULL,
    input wire logic TX_SHIFT_EMPTY,
    input wire logic FIFO_FULL,
    input wire logic FIFO_EMPTY,
    input wire logic CARD_DATA_LINE3_PIN,
    input wire logic CARD_BUSY_PIN,
    output logic CARD_CLOCK_PIN,
    output logic MEM_CLOCK_TICK
);
    import chsto_pkg::*;

    localparam int SW = `CHSTO_STATUS_W;

    // widths beyond the register fields cannot be programmed
    if (RESP_W < 1 || RESP_W > 8 || DIV_W < 1 || DIV_W > 8 ||
        READ_W < 17 || READ_W > 26) begin : g_bad_width
        $error("chsto_regs: unsupported parameter width");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic line3_meta;
    logic line3_level;
    logic line3_prev;
    logic busy_meta;
    logic card_busy;

    // two flops before any logic looks at the card pins
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            line3_meta <= 1'b0;
            line3_level <= 1'b0;
            line3_prev <= 1'b0;
            busy_meta <= 1'b0;
            card_busy <= 1'b0;
        end else begin
            line3_meta <= CARD_DATA_LINE3_PIN;
            line3_level <= line3_meta;
            line3_prev <= line3_level;
            busy_meta <= CARD_BUSY_PIN;
            card_busy <= busy_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic [10:0] clock_ctrl;
    logic [SW-1:0] main_status;
    logic [SW-1:0] interrupt_enable;
    logic [31:0] response_wait_limit;
    logic [31:0] read_data_wait_limit;
    logic ack;

    wire access = PSEL & PENABLE;
    wire hit_clk = (PADDR == `CHSTO_OFF_CLOCK_CTRL);
    wire hit_main = (PADDR == `CHSTO_OFF_MAIN_STATUS);
    wire hit_sec = (PADDR == `CHSTO_OFF_SECONDARY_STATUS);
    wire hit_ien = (PADDR == `CHSTO_OFF_INTERRUPT_ENABLE);
    wire hit_resp = (PADDR == `CHSTO_OFF_RESPONSE_WAIT_LIMIT);
    wire hit_read = (PADDR == `CHSTO_OFF_READ_DATA_WAIT_LIMIT);
    wire mapped = hit_clk | hit_main | hit_sec | hit_ien | hit_resp |
                  hit_read;
    wire done = access & ack;
    wire wr = done & PWRITE & mapped;
    wire rd = done & ~PWRITE;

    // one wait state so read data can come from a flop
    assign PREADY = ack;
    assign PSLVERR = ack & ~mapped;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock control and memory clock divider

    wire [DIV_W-1:0] card_clock_divider =
        clock_ctrl[`CHSTO_CLK_DIVIDER_LSB +: DIV_W];
    wire card_clock_enable = clock_ctrl[`CHSTO_CLK_ENABLE_BIT];
    wire [1:0] edge_sel = clock_ctrl[`CHSTO_CLK_EDGE_LSB +: 2];

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            clock_ctrl <= `CHSTO_CLK_CTRL_RESET;
        end else if (wr && hit_clk) begin
            clock_ctrl <= PWDATA[10:0];
        end
    end

    // stop covers manual disable and shift register stalls
    wire card_clock_stopped = ~card_clock_enable | RX_SHIFT_FULL |
                              TX_SHIFT_EMPTY;

    logic [DIV_W-1:0] div_count;
    logic mem_clock;
    wire div_wrap = (div_count == card_clock_divider);
    wire [DIV_W-1:0] next_div_count =
        div_wrap ? '0 : DIV_W'(div_count + 1'b1);

    // half period is divider+1 cycles, so full period 2(divider+1)
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            div_count <= '0;
            mem_clock <= 1'b0;
        end else begin
            div_count <= next_div_count;
            if (div_wrap) begin
                mem_clock <= ~mem_clock;
            end
        end
    end

    // time-outs count memory clock cycles even while the pin is stopped,
    // so a wait can still expire when the card stalls the link
    assign MEM_CLOCK_TICK = div_wrap & ~mem_clock;
    assign CARD_CLOCK_PIN = mem_clock & ~card_clock_stopped;

    ////////////////////////////////////////////////////////////////////////
    // wait limit registers

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            response_wait_limit <= `CHSTO_WAIT_LIMIT_RESET;
            read_data_wait_limit <= `CHSTO_WAIT_LIMIT_RESET;
        end else begin
            if (wr && hit_resp) begin
                response_wait_limit <= {14'h0, PWDATA[17:0]};
            end
            if (wr && hit_read) begin
                read_data_wait_limit <= {16'h0000, PWDATA[15:0]};
            end
        end
    end

    wire [RESP_W-1:0] resp_wait_count =
        response_wait_limit[`CHSTO_RESP_COUNT_LSB +: RESP_W];
    wire [9:0] read_wait_count_high =
        response_wait_limit[`CHSTO_READ_HIGH_LSB +: 10];
    wire [15:0] read_wait_count_low =
        read_data_wait_limit[`CHSTO_READ_LOW_LSB +: 16];
    wire [25:0] read_full = {read_wait_count_high, read_wait_count_low};
    wire [READ_W-1:0] read_limit = read_full[READ_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // response time-out counter

    chsto_wait_t resp_state;
    logic [RESP_W-1:0] resp_count;
    wire [RESP_W-1:0] resp_count_inc = RESP_W'(resp_count + 1'b1);
    wire resp_expire = (resp_state == CHSTO_WAITING) & ~RESP_WAIT_START &
                       ~RESP_ARRIVED & MEM_CLOCK_TICK &
                       (resp_wait_count != '0) &
                       (resp_count_inc == resp_wait_count);

    // a new start always wins so a back to back command restarts cleanly
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            resp_state <= CHSTO_IDLE;
            resp_count <= '0;
        end else if (RESP_WAIT_START) begin
            resp_state <= CHSTO_WAITING;
            resp_count <= '0;
        end else begin
            case (resp_state)
                CHSTO_IDLE: begin
                    resp_count <= resp_count;
                end
                CHSTO_WAITING: begin
                    if (RESP_ARRIVED || resp_expire) begin
                        resp_state <= CHSTO_IDLE;
                    end else if (MEM_CLOCK_TICK) begin
                        resp_count <= resp_count_inc;
                    end
                end
                default: resp_state <= CHSTO_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data time-out counter

    chsto_wait_t read_state;
    logic [READ_W-1:0] read_count;
    wire [READ_W-1:0] read_count_inc = READ_W'(read_count + 1'b1);
    wire read_expire = (read_state == CHSTO_WAITING) & ~READ_WAIT_START &
                       ~READ_ARRIVED & MEM_CLOCK_TICK &
                       (read_limit != '0) &
                       (read_count_inc == read_limit);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            read_state <= CHSTO_IDLE;
            read_count <= '0;
        end else if (READ_WAIT_START) begin
            read_state <= CHSTO_WAITING;
            read_count <= '0;
        end else begin
            case (read_state)
                CHSTO_IDLE: begin
                    read_count <= read_count;
                end
                CHSTO_WAITING: begin
                    if (READ_ARRIVED || read_expire) begin
                        read_state <= CHSTO_IDLE;
                    end else if (MEM_CLOCK_TICK) begin
                        read_count <= read_count_inc;
                    end
                end
                default: read_state <= CHSTO_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line 3 edge detection

    wire rise = line3_level & ~line3_prev;
    wire fall = ~line3_level & line3_prev;
    wire line3_edge = (rise & edge_sel[0]) | (fall & edge_sel[1]);

    ////////////////////////////////////////////////////////////////////////
    // main status: sticky flags

    logic [SW-1:0] set_ev;
    logic [SW-1:0] func_clear;

    // each event lands on its own flag position
    always_comb begin
        set_ev = '0;
        func_clear = '0;
        set_ev[`CHSTO_BIT_CMD_COMPLETE] = CMD_COMPLETE;
        set_ev[`CHSTO_BIT_TRANSFER_DONE] = TRANSFER_DONE;
        set_ev[`CHSTO_BIT_LINE3_EDGE] = line3_edge;
        set_ev[`CHSTO_BIT_RX_READY] = RX_READY_SET;
        set_ev[`CHSTO_BIT_TX_READY] = TX_READY_SET;
        set_ev[`CHSTO_BIT_RESP_CRC] = RESP_CRC_ERROR;
        set_ev[`CHSTO_BIT_READ_CRC] = READ_CRC_ERROR;
        set_ev[`CHSTO_BIT_WRITE_CRC] = WRITE_CRC_ERROR;
        set_ev[`CHSTO_BIT_RESP_TIMEOUT] = resp_expire;
        set_ev[`CHSTO_BIT_READ_TIMEOUT] = read_expire;
        set_ev[`CHSTO_BIT_RESP_DONE] = RESP_DONE;
        set_ev[`CHSTO_BIT_BUSY_DONE] = BUSY_DONE;
        set_ev[`CHSTO_BIT_DATA_DONE] = DATA_DONE;
        func_clear[`CHSTO_BIT_RX_READY] = RX_READY_CLEAR;
        func_clear[`CHSTO_BIT_TX_READY] = TX_READY_CLEAR;
    end

    // ready flags are immune to read and write-one clears
    wire [SW-1:0] read_clear = (rd && hit_main) ?
        `CHSTO_READ_CLEAR_MASK : '0;
    wire [SW-1:0] write_clear = (wr && hit_main) ?
        (PWDATA[SW-1:0] & `CHSTO_READ_CLEAR_MASK) : '0;
    wire [SW-1:0] clear_any = read_clear | write_clear | func_clear;

    genvar g;
    generate
        for (g = 0; g < SW; g++) begin : g_flag
            localparam logic [SW-1:0] RST_V = `CHSTO_MAIN_STATUS_RESET;
            // set beats clear so no event is lost to a racing read
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    main_status[g] <= RST_V[g];
                end else if (set_ev[g]) begin
                    main_status[g] <= 1'b1;
                end else if (clear_any[g]) begin
                    main_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt enable and interrupt output

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            interrupt_enable <= '0;
        end else if (wr && hit_ien) begin
            interrupt_enable <= PWDATA[SW-1:0] & `CHSTO_WRITABLE_MASK;
        end
    end

    // a flag only rises from 0, so the level follows each new event;
    // secondary status is not part of this term at all
    wire irq_terms = |(main_status & interrupt_enable);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_terms;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // secondary status and read data

    logic [31:0] secondary_status;

    always_comb begin
        secondary_status = '0;
        secondary_status[`CHSTO_SEC_FIFO_FULL] = FIFO_FULL;
        secondary_status[`CHSTO_SEC_FIFO_EMPTY] = FIFO_EMPTY;
        secondary_status[`CHSTO_SEC_LINE3_LEVEL] = line3_level;
        secondary_status[`CHSTO_SEC_RX_SHIFT_FULL] = RX_SHIFT_FULL;
        secondary_status[`CHSTO_SEC_TX_SHIFT_EMPTY] = TX_SHIFT_EMPTY;
        secondary_status[`CHSTO_SEC_CLOCK_STOPPED] = card_clock_stopped;
        secondary_status[`CHSTO_SEC_CARD_BUSY] = card_busy;
    end

    wire [31:0] rd_mux =
        hit_clk ? {21'h0, clock_ctrl} :
        hit_main ? {18'h0, main_status} :
        hit_sec ? secondary_status :
        hit_ien ? {18'h0, interrupt_enable} :
        hit_resp ? response_wait_limit :
        hit_read ? read_data_wait_limit : 32'h00000000;

    // captured in the first access cycle, shown while pready is high
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (access && !ack && !PWRITE) begin
            PRDATA <= rd_mux;
        end
    end
endmodule

// ===== tb/chsto_card_model.sv
// card side model driving the line 3 and busy pins
module chsto_card_model (
    input wire logic CLOCK,
    input wire logic line3_req,
    input wire logic busy_req,
    output logic CARD_DATA_LINE3_PIN,
    output logic CARD_BUSY_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // the card moves its pins after a clock edge, never mid-cycle
    always_ff @(posedge CLOCK) begin
        CARD_DATA_LINE3_PIN <= line3_req;
        CARD_BUSY_PIN <= busy_req;
    end
endmodule

// ===== tb/chsto_regs_properties.sv
// port assertions of the card status and time-out registers
`include "chsto_defines.svh"
module chsto_regs_properties (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`CHSTO_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic RX_READY_CLEAR,
    input wire logic TX_READY_CLEAR,
    input wire logic RX_SHIFT_FULL,
    input wire logic TX_SHIFT_EMPTY,
    input wire logic FIFO_FULL,
    input wire logic FIFO_EMPTY,
    input wire logic CARD_DATA_LINE3_PIN,
    input wire logic CARD_BUSY_PIN,
    input wire logic CARD_CLOCK_PIN
);
    logic [4:0] line3_hist;
    logic [4:0] busy_hist;
    wire logic [3:0] lv;
    wire logic sec_rd;
    wire logic mapped;
    assign lv = {FIFO_FULL, FIFO_EMPTY, RX_SHIFT_FULL, TX_SHIFT_EMPTY};
    assign sec_rd = PREADY && !PWRITE
        && PADDR == `CHSTO_OFF_SECONDARY_STATUS;
    assign mapped = PADDR inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    // pin history: levels are judged only once the synchroniser settled
    always_ff @(posedge CLOCK) begin
        line3_hist <= {line3_hist[3:0], CARD_DATA_LINE3_PIN};
        busy_hist <= {busy_hist[3:0], CARD_BUSY_PIN};
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    property p_one_wait;
        (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("access did not end after one wait state");
    property p_slverr_map;
        PREADY |-> PSLVERR == !mapped;
    endproperty
    a_slverr_map: assert property (p_slverr_map)
        else $error("error response does not match address map");
    property p_refused_zero;
        PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h00000000;
    endproperty
    a_refused_zero: assert property (p_refused_zero)
        else $error("unmapped read returned data");
    property p_clock_hold;
        RX_SHIFT_FULL || TX_SHIFT_EMPTY |-> !CARD_CLOCK_PIN;
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("card clock runs while shift register stalls");
    property p_irq_fall;
        $fell(IRQ) |-> $past(PREADY, 2) || $past(RX_READY_CLEAR, 2)
            || $past(TX_READY_CLEAR, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a clearing cause");
    property p_sec_levels;
        sec_rd && $past(lv) == $past(lv, 2) |->
            PRDATA[6:5] == $past(lv[3:2]) && PRDATA[3:2] == $past(lv[1:0])
            && PRDATA[31:7] == 25'h0000000;
    endproperty
    a_sec_levels: assert property (p_sec_levels)
        else $error("secondary status levels wrong");
    property p_line3;
        sec_rd && (&line3_hist || !(|line3_hist)) |->
            PRDATA[4] == line3_hist[0];
    endproperty
    a_line3: assert property (p_line3)
        else $error("line 3 level wrong in secondary status");
    property p_busy;
        sec_rd && (&busy_hist || !(|busy_hist)) |-> PRDATA[0] == busy_hist[0];
    endproperty
    a_busy: assert property (p_busy)
        else $error("card busy wrong in secondary status");
    property p_reset;
        $fell(RST) |-> !IRQ && !PREADY && !CARD_CLOCK_PIN;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not quiet after reset");
endmodule
bind chsto_regs chsto_regs_properties chsto_regs_properties_inst (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .RX_READY_CLEAR(RX_READY_CLEAR),
    .TX_READY_CLEAR(TX_READY_CLEAR), .RX_SHIFT_FULL(RX_SHIFT_FULL),
    .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .FIFO_FULL(FIFO_FULL),
    .FIFO_EMPTY(FIFO_EMPTY), .CARD_DATA_LINE3_PIN(CARD_DATA_LINE3_PIN),
    .CARD_BUSY_PIN(CARD_BUSY_PIN), .CARD_CLOCK_PIN(CARD_CLOCK_PIN));

// ===== tb/test_card_host_status_timeout_regs.sv
// self-checking bench of the card status and time-out registers
`include "chsto_defines.svh"
module test_card_host_status_timeout_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EV_POS [8] = '{13, 12, 0, 2, 1, 7, 6, 5};
    logic CLOCK, RST, psel, penable, pwrite, line3_req, busy_req;
    logic [7:0] paddr, ev, pl;
    logic [31:0] pwdata, q;
    logic [3:0] lv;
    logic err, saw_high;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, line3, busy, card_clk, tick;
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    chsto_regs chsto_regs_inst (.CLOCK(CLOCK), .RST(RST), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .CMD_COMPLETE(ev[0]), .TRANSFER_DONE(ev[1]), .DATA_DONE(ev[2]),
        .RESP_DONE(ev[3]), .BUSY_DONE(ev[4]), .RESP_CRC_ERROR(ev[5]),
        .READ_CRC_ERROR(ev[6]), .WRITE_CRC_ERROR(ev[7]),
        .RX_READY_SET(pl[0]), .RX_READY_CLEAR(pl[1]), .TX_READY_SET(pl[2]),
        .TX_READY_CLEAR(pl[3]), .RESP_WAIT_START(pl[4]),
        .RESP_ARRIVED(pl[5]), .READ_WAIT_START(pl[6]), .READ_ARRIVED(pl[7]),
        .RX_SHIFT_FULL(lv[1]), .TX_SHIFT_EMPTY(lv[0]), .FIFO_FULL(lv[3]),
        .FIFO_EMPTY(lv[2]), .CARD_DATA_LINE3_PIN(line3),
        .CARD_BUSY_PIN(busy), .CARD_CLOCK_PIN(card_clk),
        .MEM_CLOCK_TICK(tick));
    chsto_card_model chsto_card_model_inst (.CLOCK(CLOCK),
        .line3_req(line3_req), .busy_req(busy_req),
        .CARD_DATA_LINE3_PIN(line3), .CARD_BUSY_PIN(busy));
    // 25 MHz function clock
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // apb transfer; reads at the active region see the pre-edge values
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge CLOCK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge CLOCK);
        penable <= 1'b1;
        do begin
            @(posedge CLOCK);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) num_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(q, exp);
    endtask
    // one-cycle pulse on an event line or a ready or wait control line
    task automatic pulse(input bit sel, input int i);
        @(posedge CLOCK);
        if (sel) pl[i] <= 1'b1;
        else ev[i] <= 1'b1;
        @(posedge CLOCK);
        pl <= 8'h00;
        ev <= 8'h00;
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            do @(posedge CLOCK); while (tick !== 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard, well beyond the length of the sequence
    initial begin
        repeat (20000) @(posedge CLOCK);
        num_errors++;
        finish_test();
    end
    initial begin
        {RST, psel, penable, pwrite, paddr, pwdata} = '0;
        {ev, pl, lv, line3_req, busy_req} = '0;
        RST = 1'b1;
        repeat (16) @(posedge CLOCK);
        RST <= 1'b0;
        rd_chk(8'h08, 32'h00000200);
        rd_chk(8'h10, 32'h00000000);
        rd_chk(8'h14, 32'h00000000);
        rd_chk(8'h18, 32'h00000000);
        lv <= 4'b0110;
        line3_req <= 1'b1;
        repeat (6) @(posedge CLOCK);
        rd_chk(8'h0c, 32'h0000003a);
        lv <= 4'b1001;
        line3_req <= 1'b0;
        busy_req <= 1'b1;
        repeat (6) @(posedge CLOCK);
        rd_chk(8'h0c, 32'h00000047);
        apb(1'b1, 8'h1c, 32'hffffffff);
        check(err, 1'b1);
        rd_chk(8'h1c, 32'h00000000);
        check(err, 1'b1);
        apb(1'b1, 8'h10, 32'hffffffff);
        rd_chk(8'h10, 32'h00003eff);
        apb(1'b1, 8'h14, 32'hffffffff);
        rd_chk(8'h14, 32'h0003ffff);
        apb(1'b1, 8'h18, 32'hffffffff);
        rd_chk(8'h18, 32'h0000ffff);
        apb(1'b1, 8'h10, 32'h00000000);
        // each event sets its own bit, a read clears it again
        for (int i = 0; i < 8; i++) begin
            pulse(1'b0, i);
            rd_chk(8'h08, 32'h00000200 | (32'h1 << EV_POS[i]));
            rd_chk(8'h08, 32'h00000200);
        end
        pulse(1'b1, 0);
        rd_chk(8'h08, 32'h00000600);
        rd_chk(8'h08, 32'h00000600);
        pulse(1'b1, 1);
        pulse(1'b1, 3);
        rd_chk(8'h08, 32'h00000000);
        pulse(1'b1, 2);
        rd_chk(8'h08, 32'h00000200);
        // masked event stays quiet, enabled one interrupts until read
        apb(1'b1, 8'h10, 32'h00000001);
        pulse(1'b0, 4);
        repeat (3) @(posedge CLOCK);
        check(irq, 1'b0);
        rd_chk(8'h08, 32'h00000202);
        pulse(1'b0, 2);
        repeat (3) @(posedge CLOCK);
        check(irq, 1'b1);
        rd_chk(8'h08, 32'h00000201);
        repeat (3) @(posedge CLOCK);
        check(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h00003cff);
        lv <= 4'b0110;
        line3_req <= 1'b1;
        busy_req <= 1'b0;
        repeat (8) @(posedge CLOCK);
        check(irq, 1'b0);
        // divider 2 with the pin running
        {lv, line3_req} <= '0;
        apb(1'b1, 8'h04, 32'h00000102);
        ticks(1);
        n = 0;
        saw_high = 1'b0;
        do begin
            @(posedge CLOCK);
            n++;
            saw_high = saw_high | card_clk;
        end while (tick !== 1'b1 && n < 20);
        check(n, 6);
        check(saw_high, 1'b1);
        rd_chk(8'h0c, 32'h00000000);
        // response limit 3, restarted once, then left to expire
        apb(1'b1, 8'h04, 32'h00000100);
        apb(1'b1, 8'h10, 32'h00000018);
        apb(1'b1, 8'h14, 32'h00000003);
        pulse(1'b1, 4);
        ticks(2);
        pulse(1'b1, 4);
        ticks(2);
        @(posedge CLOCK);
        check(irq, 1'b0);
        ticks(1);
        repeat (4) @(posedge CLOCK);
        check(irq, 1'b1);
        rd_chk(8'h08, 32'h00000210);
        pulse(1'b1, 4);
        ticks(2);
        pulse(1'b1, 5);
        ticks(6);
        check(irq, 1'b0);
        apb(1'b1, 8'h14, 32'h00000000);
        pulse(1'b1, 4);
        ticks(8);
        check(irq, 1'b0);
        // read limit 2 from the low half, upper bits zero
        apb(1'b1, 8'h18, 32'h00000002);
        pulse(1'b1, 6);
        ticks(2);
        repeat (4) @(posedge CLOCK);
        check(irq, 1'b1);
        rd_chk(8'h08, 32'h00000208);
        // rising edge select: a line 3 rise records the edge flag
        apb(1'b1, 8'h04, 32'h00000300);
        line3_req <= 1'b1;
        repeat (6) @(posedge CLOCK);
        rd_chk(8'h08, 32'h00000a00);
        finish_test();
    end
endmodule
